// ### verilog/bafc_top.sv
// Bootstrap flash checksums and serial autobaud synchronisation with acknowledge.
//
// What this block does
// - Checksum adds byte then rotates left
// - Separate checksums for odd and even addresses
// - Framing is eight data, no parity, two stop
// - Poll receive input, time byte with timer
// - Interval spans start bit plus eight data
// - Timer advances once per twelve oscillator periods
// - Reload is 1024 minus 171 times count shifted
// - Round by the last bit shifted out
// - Reload drives ten-bit baud generator, divide 32
// - Send acknowledge 55 hex after enabling generator
// - No success check; only reset restarts
// - Counts above 24540 underflow the reload; range flag set above 24556
// - Synchronise only after both sectors failed
`timescale 1ns/10ps
module bafc_top
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic checksum_clear_i,
	input wire logic flash_byte_valid_i,
	input wire logic flash_addr_odd_i,
	input wire logic [7:0] flash_byte_i,
	input wire logic flash_check_failed_i,
	input wire logic serial_receive_input_i,
	output logic [7:0] checksum_odd_o,
	output logic [7:0] checksum_even_o,
	output logic [15:0] measured_byte_time_count_o,
	output logic [9:0] baud_reload_value_o,
	output logic baud_gen_enable_o,
	output logic count_out_of_range_o,
	output logic sync_done_o,
	output logic serial_transmit_o
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// One checksum step: add the byte, then rotate the 8-bit sum left by one.
	function automatic logic [7:0] bafc_add_rotate(input logic [7:0] acc, input logic [7:0] data);
		logic [7:0] sum;
		sum = acc + data;
		return {sum[6:0], sum[7]};
	endfunction : bafc_add_rotate

	// Reload from a timer count: full scale minus the rounded scaled product.
	// The subtraction is allowed to wrap, which is the underflow seen from a count of 24541, below the supported maximum of 24556.
	function automatic logic [9:0] bafc_reload_from_count(input logic [15:0] count);
		logic [23:0] product;
		logic [11:0] quotient;
		logic [10:0] diff;
		product = 24'(count) * 24'(bafc_pkg::RELOAD_FACTOR);
		quotient = product[23:bafc_pkg::SCALE_SHIFT] + {11'h000, product[bafc_pkg::SCALE_SHIFT - 1]};
		diff = bafc_pkg::RELOAD_FULL_SCALE - quotient[10:0];
		return diff[9:0];
	endfunction : bafc_reload_from_count

	// ----------------------------------------------------------------
	// Flash checksum accumulators
	// ----------------------------------------------------------------
	logic [7:0] chk_odd_q, chk_odd_d;
	logic [7:0] chk_even_q, chk_even_d;

	// Each byte outside a clear cycle goes to exactly one accumulator chosen by its address parity.
	always_comb
	begin
		chk_odd_d = chk_odd_q;
		chk_even_d = chk_even_q;
		if (checksum_clear_i)
		begin
			chk_odd_d = bafc_pkg::CHECKSUM_INIT;
			chk_even_d = bafc_pkg::CHECKSUM_INIT;
		end
		else if (flash_byte_valid_i)
		begin
			if (flash_addr_odd_i)
			begin
				chk_odd_d = bafc_add_rotate(chk_odd_q, flash_byte_i);
			end
			else
			begin
				chk_even_d = bafc_add_rotate(chk_even_q, flash_byte_i);
			end
		end
	end

	// Registers of the checksum accumulators.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			chk_odd_q <= bafc_pkg::CHECKSUM_INIT;
			chk_even_q <= bafc_pkg::CHECKSUM_INIT;
		end
		else
		begin
			chk_odd_q <= chk_odd_d;
			chk_even_q <= chk_even_d;
		end
	end

	// ----------------------------------------------------------------
	// Receive input synchroniser
	// ----------------------------------------------------------------
	logic rxd_meta_q;
	logic rxd_sync_q;

	// Two flops; only the second one is looked at by the sequencer.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rxd_meta_q <= 1'b1;
			rxd_sync_q <= 1'b1;
		end
		else
		begin
			rxd_meta_q <= serial_receive_input_i;
			rxd_sync_q <= rxd_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Synchronisation sequencer, measurement timer and reload
	// ----------------------------------------------------------------
	bafc_pkg::bafc_sync_e state_q, state_d;
	logic [3:0] prescale_q, prescale_d;
	logic [15:0] t0_q, t0_d;
	logic [9:0] reload_q, reload_d;
	logic baud_en_q, baud_en_d;
	logic range_err_q, range_err_d;
	logic send_q, send_d;
	logic done_q, done_d;
	logic tx_busy;
	logic timer_tick;

	// The timer steps once every twelve clocks; the prescaler restarts at the start edge.
	assign timer_tick = (prescale_q == bafc_pkg::PRESCALE_LAST);

	// The receive line is polled each clock, so the start edge is resolved to one clock,
	// which is well below one timer step and does not disturb the count.
	always_comb
	begin
		state_d = state_q;
		prescale_d = prescale_q;
		t0_d = t0_q;
		reload_d = reload_q;
		baud_en_d = baud_en_q;
		range_err_d = range_err_q;
		send_d = 1'b0;
		done_d = done_q;
		case (state_q)
			bafc_pkg::SYNC_WAIT_FAIL:
			begin
				if (flash_check_failed_i)
				begin
					state_d = bafc_pkg::SYNC_WAIT_IDLE;
				end
			end
			bafc_pkg::SYNC_WAIT_IDLE:
			begin
				// A line already low is not taken as a start edge.
				if (rxd_sync_q)
				begin
					state_d = bafc_pkg::SYNC_WAIT_START;
				end
			end
			bafc_pkg::SYNC_WAIT_START:
			begin
				if (!rxd_sync_q)
				begin
					prescale_d = 4'h0;
					t0_d = 16'h0000;
					state_d = bafc_pkg::SYNC_MEASURE;
				end
			end
			bafc_pkg::SYNC_MEASURE:
			begin
				prescale_d = timer_tick ? 4'h0 : prescale_q + 4'h1;
				if (timer_tick)
				begin
					t0_d = t0_q + 16'h0001;
				end
				// A zero byte keeps the line low through start and eight data bits,
				// so the first rise is the first stop bit.
				if (rxd_sync_q)
				begin
					state_d = bafc_pkg::SYNC_CALC;
				end
			end
			bafc_pkg::SYNC_CALC:
			begin
				reload_d = bafc_reload_from_count(t0_q);
				range_err_d = (t0_q > bafc_pkg::T0_SUPPORTED_MAX);
				baud_en_d = 1'b1;
				state_d = bafc_pkg::SYNC_SEND;
			end
			bafc_pkg::SYNC_SEND:
			begin
				// The generator is already running when the acknowledge is queued.
				if (!tx_busy && !send_q)
				begin
					send_d = 1'b1;
					state_d = bafc_pkg::SYNC_DONE;
				end
			end
			bafc_pkg::SYNC_DONE:
			begin
				// No check of the host's answer: the sequence stays here until reset.
				if (!tx_busy && !send_q)
				begin
					done_d = 1'b1;
				end
			end
			default:
			begin
				state_d = bafc_pkg::SYNC_WAIT_FAIL;
			end
		endcase
	end

	// Registers of the sequencer; reset is the only way back to the start.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= bafc_pkg::SYNC_WAIT_FAIL;
			prescale_q <= 4'h0;
			t0_q <= 16'h0000;
			reload_q <= bafc_pkg::RELOAD_RESET;
			baud_en_q <= 1'b0;
			range_err_q <= 1'b0;
			send_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			prescale_q <= prescale_d;
			t0_q <= t0_d;
			reload_q <= reload_d;
			baud_en_q <= baud_en_d;
			range_err_q <= range_err_d;
			send_q <= send_d;
			done_q <= done_d;
		end
	end

	// ----------------------------------------------------------------
	// Baud rate generator
	// ----------------------------------------------------------------
	logic [9:0] baud_cnt_q, baud_cnt_d;
	logic [4:0] baud_div_q, baud_div_d;
	logic bit_tick_q, bit_tick_d;

	// The counter reloads on overflow, giving one overflow per (1024 - reload) clocks;
	// thirty-two overflows make one bit time.
	always_comb
	begin
		baud_cnt_d = baud_cnt_q;
		baud_div_d = baud_div_q;
		bit_tick_d = 1'b0;
		if (!baud_en_q)
		begin
			baud_cnt_d = reload_d;
			baud_div_d = 5'h00;
		end
		else if (baud_cnt_q == bafc_pkg::RELOAD_MAX)
		begin
			baud_cnt_d = reload_q;
			baud_div_d = baud_div_q + 5'h01;
			bit_tick_d = (baud_div_q == bafc_pkg::BAUD_DIV_LAST);
		end
		else
		begin
			baud_cnt_d = baud_cnt_q + 10'h001;
		end
	end

	// Registers of the baud rate generator.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			baud_cnt_q <= bafc_pkg::RELOAD_RESET;
			baud_div_q <= 5'h00;
			bit_tick_q <= 1'b0;
		end
		else
		begin
			baud_cnt_q <= baud_cnt_d;
			baud_div_q <= baud_div_d;
			bit_tick_q <= bit_tick_d;
		end
	end

	// ----------------------------------------------------------------
	// Acknowledge transmitter
	// ----------------------------------------------------------------
	bafc_ack_tx u_ack_tx
	(
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.bit_tick_i(bit_tick_q),
		.send_i(send_q),
		.data_i(bafc_pkg::ACK_BYTE),
		.txd_o(serial_transmit_o),
		.busy_o(tx_busy)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign checksum_odd_o = chk_odd_q;
	assign checksum_even_o = chk_even_q;
	assign measured_byte_time_count_o = t0_q;
	assign baud_reload_value_o = reload_q;
	assign baud_gen_enable_o = baud_en_q;
	assign count_out_of_range_o = range_err_q;
	assign sync_done_o = done_q;

endmodule : bafc_top

// ### verilog/bafc_pkg.sv
// Shared constants and state types for the bootstrap autobaud and flash checksum block.
package bafc_pkg;

	// ----------------------------------------------------------------
	// Serial framing and measurement constants
	// ----------------------------------------------------------------
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned STOP_BITS = 2;
	localparam int unsigned MEASURED_BIT_COUNT = 9;
	localparam int unsigned OSC_PER_TIMER_TICK = 12;
	localparam int unsigned BAUD_DIVIDE = 32;
	localparam int unsigned SCALE_SHIFT = 12;
	localparam int unsigned SCALE = 4096;

	// Scaled factor 12 / (32 * 9) times 4096, rounded to the nearest integer (171).
	localparam int unsigned RELOAD_FACTOR =
		(SCALE * OSC_PER_TIMER_TICK + (BAUD_DIVIDE * MEASURED_BIT_COUNT) / 2) /
		(BAUD_DIVIDE * MEASURED_BIT_COUNT);

	// ----------------------------------------------------------------
	// Widths, limits and reset values
	// ----------------------------------------------------------------
	localparam int unsigned T0_W = 16;
	localparam int unsigned RELOAD_W = 10;
	localparam int unsigned PRODUCT_W = 24;
	localparam logic [3:0] PRESCALE_LAST = 4'(OSC_PER_TIMER_TICK - 1);
	localparam logic [4:0] BAUD_DIV_LAST = 5'(BAUD_DIVIDE - 1);
	localparam logic [2:0] DATA_BIT_LAST = 3'(DATA_BITS - 1);
	localparam logic [1:0] STOP_BIT_LAST = 2'(STOP_BITS - 1);
	localparam logic [10:0] RELOAD_FULL_SCALE = 11'h400;
	localparam logic [9:0] RELOAD_MAX = 10'h3FF;
	localparam logic [15:0] T0_SUPPORTED_MAX = 16'h5FEC;
	localparam logic [7:0] ACK_BYTE = 8'h55;
	localparam logic [7:0] CHECKSUM_INIT = 8'h00;
	localparam logic [9:0] RELOAD_RESET = 10'h000;

	// ----------------------------------------------------------------
	// State machines, Gray coded along the usual path except TX_STOP back to TX_IDLE
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SYNC_WAIT_FAIL = 3'h0,
		SYNC_WAIT_IDLE = 3'h1,
		SYNC_WAIT_START = 3'h3,
		SYNC_MEASURE = 3'h2,
		SYNC_CALC = 3'h6,
		SYNC_SEND = 3'h7,
		SYNC_DONE = 3'h5
	} bafc_sync_e;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_ARM = 3'h1,
		TX_START = 3'h3,
		TX_DATA = 3'h2,
		TX_STOP = 3'h6
	} bafc_tx_e;

endpackage : bafc_pkg

// ### verilog/bafc_ack_tx.sv
// Byte transmitter with eight data bits, no parity and two stop bits, paced by bit ticks.
`timescale 1ns/10ps
module bafc_ack_tx
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic bit_tick_i,
	input wire logic send_i,
	input wire logic [7:0] data_i,
	output logic txd_o,
	output logic busy_o
);

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	bafc_pkg::bafc_tx_e state_q, state_d;
	logic [7:0] shift_q, shift_d;
	logic [2:0] bit_idx_q, bit_idx_d;
	logic [1:0] stop_idx_q, stop_idx_d;
	logic txd_q, txd_d;

	// The first tick after a send only aligns the frame, so the start bit is never shortened.
	always_comb
	begin
		state_d = state_q;
		shift_d = shift_q;
		bit_idx_d = bit_idx_q;
		stop_idx_d = stop_idx_q;
		txd_d = txd_q;
		case (state_q)
			bafc_pkg::TX_IDLE:
			begin
				txd_d = 1'b1;
				if (send_i)
				begin
					shift_d = data_i;
					state_d = bafc_pkg::TX_ARM;
				end
			end
			bafc_pkg::TX_ARM:
			begin
				if (bit_tick_i)
				begin
					txd_d = 1'b0;
					state_d = bafc_pkg::TX_START;
				end
			end
			bafc_pkg::TX_START:
			begin
				if (bit_tick_i)
				begin
					txd_d = shift_q[0];
					shift_d = {1'b0, shift_q[7:1]};
					bit_idx_d = 3'h0;
					state_d = bafc_pkg::TX_DATA;
				end
			end
			bafc_pkg::TX_DATA:
			begin
				if (bit_tick_i)
				begin
					if (bit_idx_q == bafc_pkg::DATA_BIT_LAST)
					begin
						txd_d = 1'b1;
						stop_idx_d = 2'h0;
						state_d = bafc_pkg::TX_STOP;
					end
					else
					begin
						txd_d = shift_q[0];
						shift_d = {1'b0, shift_q[7:1]};
						bit_idx_d = bit_idx_q + 3'h1;
					end
				end
			end
			bafc_pkg::TX_STOP:
			begin
				if (bit_tick_i)
				begin
					if (stop_idx_q == bafc_pkg::STOP_BIT_LAST)
					begin
						state_d = bafc_pkg::TX_IDLE;
					end
					else
					begin
						stop_idx_d = stop_idx_q + 2'h1;
					end
				end
			end
			default:
			begin
				state_d = bafc_pkg::TX_IDLE;
				txd_d = 1'b1;
			end
		endcase
	end

	// Registers of the frame sequencer; the line idles high.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= bafc_pkg::TX_IDLE;
			shift_q <= 8'h00;
			bit_idx_q <= 3'h0;
			stop_idx_q <= 2'h0;
			txd_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			shift_q <= shift_d;
			bit_idx_q <= bit_idx_d;
			stop_idx_q <= stop_idx_d;
			txd_q <= txd_d;
		end
	end

	assign txd_o = txd_q;
	assign busy_o = (state_q != bafc_pkg::TX_IDLE);

endmodule : bafc_ack_tx

// ### testbench/bafc_sva.sv
// Checker for the autobaud and flash checksum block, watching its ports only.
`timescale 1ns/10ps
module bafc_sva
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic checksum_clear_i,
	input wire logic flash_byte_valid_i,
	input wire logic flash_addr_odd_i,
	input wire logic [7:0] flash_byte_i,
	input wire logic flash_check_failed_i,
	input wire logic serial_receive_input_i,
	input wire logic [7:0] checksum_odd_o,
	input wire logic [7:0] checksum_even_o,
	input wire logic [15:0] measured_byte_time_count_o,
	input wire logic [9:0] baud_reload_value_o,
	input wire logic baud_gen_enable_o,
	input wire logic count_out_of_range_o,
	input wire logic sync_done_o,
	input wire logic serial_transmit_o
);
	// ----------------------------------------------------------------
	// Helpers and properties
	// ----------------------------------------------------------------
	logic [23:0] prod;
	logic [9:0] exp_reload;

	// Reload recomputed from the held count, so a rounding slip in the design shows up.
	assign prod = 24'(measured_byte_time_count_o) * 24'h0000AB;
	assign exp_reload = 10'(11'h400 - 11'(prod[23:12]) - 11'(prod[11]));

	function automatic logic [7:0] add_rot(input logic [7:0] s, input logic [7:0] b);
		logic [7:0] t;
		t = s + b;
		return {t[6:0], t[7]};
	endfunction : add_rot

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_odd_byte;
		flash_byte_valid_i && !checksum_clear_i && flash_addr_odd_i;
	endsequence
	sequence s_even_byte;
		flash_byte_valid_i && !checksum_clear_i && !flash_addr_odd_i;
	endsequence
	sequence s_loaded;
		$rose(baud_gen_enable_o);
	endsequence

	odd_sum_a: assert property (s_odd_byte |=> checksum_odd_o == add_rot($past(checksum_odd_o),
		$past(flash_byte_i)) && $stable(checksum_even_o)) else $error("odd checksum step wrong");
	even_sum_a: assert property (s_even_byte |=> checksum_even_o == add_rot($past(checksum_even_o),
		$past(flash_byte_i)) && $stable(checksum_odd_o)) else $error("even checksum step wrong");
	sum_clear_a: assert property (checksum_clear_i |=> checksum_odd_o == 8'h00 && checksum_even_o == 8'h00)
		else $error("checksum clear missed");
	reload_calc_a: assert property (s_loaded |-> baud_reload_value_o == exp_reload)
		else $error("reload value wrong");
	range_flag_a: assert property (baud_gen_enable_o |->
		count_out_of_range_o == (measured_byte_time_count_o > 16'h5FEC)) else $error("range flag wrong");
	enable_hold_a: assert property (baud_gen_enable_o |=> baud_gen_enable_o
		&& $stable(measured_byte_time_count_o) && $stable(baud_reload_value_o)) else $error("sync result moved");
	done_hold_a: assert property (sync_done_o |=> sync_done_o) else $error("done flag dropped");
	done_order_a: assert property (sync_done_o |-> baud_gen_enable_o && serial_transmit_o)
		else $error("done without enable or idle line");
	tx_quiet_a: assert property (!baud_gen_enable_o |-> serial_transmit_o)
		else $error("transmit before generator enabled");
endmodule : bafc_sva

// ### testbench/bafc_host_model.sv
// Host model: sends test bytes and receives the acknowledge, 8N2 at its own fixed rate.
`timescale 1ns/10ps
module bafc_host_model
(
	input wire logic core_clk_i,
	input wire logic dev_txd_i,
	output logic host_txd_o
);
	// ----------------------------------------------------------------
	// Host transmit and receive
	// ----------------------------------------------------------------
	initial host_txd_o = 1'b1;

	// Start bit, eight bits LSB first, two stop bits; the line idles high between frames.
	task automatic send_byte(input logic [7:0] b, input int bit_clks);
		logic [10:0] frame;
		frame = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge core_clk_i);
			host_txd_o <= frame[i];
			repeat (bit_clks - 1) @(posedge core_clk_i);
		end
	endtask : send_byte

	// Samples mid-bit at the host's own rate, which can be 2.4 percent off the device's rate.
	task automatic recv_byte(input int bit_clks, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (dev_txd_i !== 1'b0 && n < 20 * bit_clks)
		begin
			@(posedge core_clk_i);
			n++;
		end
		repeat (bit_clks / 2) @(posedge core_clk_i);
		ok = (dev_txd_i === 1'b0);
		for (int i = 0; i < 10; i++)
		begin
			repeat (bit_clks) @(posedge core_clk_i);
			if (i < 8)
				b[i] = dev_txd_i;
			else
				ok = ok && (dev_txd_i === 1'b1);
		end
	endtask : recv_byte
endmodule : bafc_host_model

// ### testbench/test_bafc_top.sv
// Self-checking bench for the bootstrap autobaud and flash checksum block.
`timescale 1ns/10ps
module test_bafc_top;
	// ----------------------------------------------------------------
	// Signals, design and host
	// ----------------------------------------------------------------
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic clear = 1'b0;
	logic valid = 1'b0;
	logic odd = 1'b0;
	logic [7:0] data = 8'h00;
	logic failed = 1'b0;
	logic rxd, txd, en, range_hi, done;
	logic [7:0] sum_odd, sum_even;
	logic [15:0] count;
	logic [9:0] reload;
	int mismatches = 0;
	int checks = 0;

	always #10 core_clk_i = ~core_clk_i;

	bafc_top dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .checksum_clear_i(clear),
		.flash_byte_valid_i(valid), .flash_addr_odd_i(odd), .flash_byte_i(data), .flash_check_failed_i(failed),
		.serial_receive_input_i(rxd), .checksum_odd_o(sum_odd), .checksum_even_o(sum_even),
		.measured_byte_time_count_o(count), .baud_reload_value_o(reload), .baud_gen_enable_o(en),
		.count_out_of_range_o(range_hi), .sync_done_o(done), .serial_transmit_o(txd));
	bafc_host_model host (.core_clk_i(core_clk_i), .dev_txd_i(txd), .host_txd_o(rxd));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic results();
		$display("comparisons %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic do_reset();
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i);
	endtask : do_reset

	// Reload from the documented scaled formula, rounded by the last bit shifted out.
	function automatic logic [9:0] calc_reload(input int cnt);
		int p;
		p = 171 * cnt;
		return 10'(1024 - (p >> 12) - ((p >> 11) & 1));
	endfunction : calc_reload

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Back-to-back bytes of alternating parity, with a clear that lands on a valid byte.
	task automatic test_checksums();
		logic [7:0] e_odd, e_even, b, t;
		e_odd = 8'h00;
		e_even = 8'h00;
		for (int i = 0; i < 12; i++)
		begin
			b = 8'(8'h3B * i + 8'hA5);
			@(posedge core_clk_i);
			valid <= 1'b1;
			odd <= i[0];
			data <= b;
			clear <= (i == 6);
			t = (i[0] ? e_odd : e_even) + b;
			t = {t[6:0], t[7]};
			if (i == 6)
				{e_odd, e_even} = 16'h0000;
			else if (i[0])
				e_odd = t;
			else
				e_even = t;
		end
		@(posedge core_clk_i);
		valid <= 1'b0;
		clear <= 1'b0;
		@(posedge core_clk_i);
		check("odd checksum", {8'h00, e_odd}, {8'h00, sum_odd});
		check("even checksum", {8'h00, e_even}, {8'h00, sum_even});
	endtask : test_checksums

	// A test byte before the flash check has failed must not start synchronisation.
	task automatic test_gating();
		host.send_byte(8'h00, 128);
		repeat (20) @(posedge core_clk_i);
		check("count before fail", 16'h0000, count);
		check("enable before fail", 16'h0000, {15'h0000, en});
	endtask : test_gating

	// Full synchronisation at a host rate of bit_clks clocks per bit.
	task automatic do_sync(input int bit_clks);
		logic [7:0] ack;
		logic ok;
		int nom;
		nom = 9 * bit_clks / 12;
		@(posedge core_clk_i);
		failed <= 1'b1;
		fork
			host.send_byte(8'h00, bit_clks);
			host.recv_byte(bit_clks, ack, ok);
		join
		// The host returns inside the second stop bit, so done can trail it by up to three quarters of a device bit.
		for (int n = 0; n < 4 * bit_clks && done !== 1'b1; n++)
			@(posedge core_clk_i);
		check("count window", 16'h0001, {15'h0000, (count >= nom - 1) && (count <= nom + 1)});
		check("reload", {6'h00, calc_reload(nom)}, {6'h00, reload});
		check("enable", 16'h0001, {15'h0000, en});
		check("range flag", 16'h0000, {15'h0000, range_hi});
		check("ack byte", 16'h0055, {8'h00, ack});
		check("ack framing", 16'h0001, {15'h0000, ok});
		check("done", 16'h0001, {15'h0000, done});
	endtask : do_sync

	// A second test byte at another rate must leave the result untouched.
	task automatic test_no_restart();
		logic [9:0] kept;
		kept = reload;
		host.send_byte(8'h00, 64);
		repeat (20) @(posedge core_clk_i);
		check("reload kept", {6'h00, kept}, {6'h00, reload});
		check("done kept", 16'h0001, {15'h0000, done});
	endtask : test_no_restart

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		do_reset();
		test_checksums();
		test_gating();
		do_sync(128);
		test_no_restart();
		do_reset();
		check("reload after reset", 16'h0000, {6'h00, reload});
		check("done after reset", 16'h0000, {15'h0000, done});
		// A host rate 2.4 percent off the nearest device rate makes the last shifted-out bit one.
		do_sync(250);
		results();
	end

	// The whole run needs about 10200 cycles; 20000 leaves nearly twice that.
	initial
	begin
		#400000;
		mismatches++;
		results();
	end
endmodule : test_bafc_top

bind bafc_top bafc_sva chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .checksum_clear_i(checksum_clear_i),
	.flash_byte_valid_i(flash_byte_valid_i), .flash_addr_odd_i(flash_addr_odd_i), .flash_byte_i(flash_byte_i),
	.flash_check_failed_i(flash_check_failed_i), .serial_receive_input_i(serial_receive_input_i),
	.checksum_odd_o(checksum_odd_o), .checksum_even_o(checksum_even_o),
	.measured_byte_time_count_o(measured_byte_time_count_o), .baud_reload_value_o(baud_reload_value_o),
	.baud_gen_enable_o(baud_gen_enable_o), .count_out_of_range_o(count_out_of_range_o),
	.sync_done_o(sync_done_o), .serial_transmit_o(serial_transmit_o));
